// ---- shared/cpa_pkg.sv ----
package cpa_pkg;

	// Register byte offsets on the APB.
	localparam logic [7:0] CPA_OFS_CMP_CTL = 8'h00;
	localparam logic [7:0] CPA_OFS_ACTION = 8'h04;
	localparam logic [7:0] CPA_OFS_DEADBAND = 8'h08;
	localparam logic [7:0] CPA_OFS_PERIOD = 8'h0c;
	localparam logic [7:0] CPA_OFS_CMP0 = 8'h10;
	localparam logic [7:0] CPA_OFS_CMP1 = 8'h14;
	localparam logic [7:0] CPA_OFS_CMP2 = 8'h18;
	localparam logic [7:0] CPA_OFS_STATUS = 8'h1c;

	// Compare control fields.
	localparam int CPA_CC_ENABLE_BIT = 15;
	localparam int CPA_CC_OUTEN_BIT = 9;
	localparam int CPA_CC_RELOAD_LSB = 10;
	localparam logic [1:0] CPA_RELOAD_IMMEDIATE = 2'h2;

	// Dead-band register fields.
	localparam int CPA_DB_ENABLE_BIT = 0;
	localparam int CPA_DB_DELAY_LSB = 4;

	// Output action field codes, two bits per output.
	localparam logic [1:0] CPA_ACT_FORCE_LOW = 2'h0;
	localparam logic [1:0] CPA_ACT_ACTIVE_LOW = 2'h1;
	localparam logic [1:0] CPA_ACT_ACTIVE_HIGH = 2'h2;
	localparam logic [1:0] CPA_ACT_FORCE_HIGH = 2'h3;

	// Reset values.
	localparam logic [15:0] CPA_RST_CMP_CTL = 16'h0000;
	localparam logic [15:0] CPA_RST_ACTION = 16'h0000;
	localparam logic [15:0] CPA_RST_PERIOD = 16'hffff;
	localparam logic [15:0] CPA_RST_CMP = 16'h0000;

	// Sizes.
	localparam int CPA_PAIRS = 3;
	localparam int CPA_OUTS = 6;

	// Dead-band configuration as one carrier.
	typedef struct packed {
		logic enable;
		logic [7:0] delay;
	} cpa_deadband_t;

	// Compare run state.
	typedef enum logic {CPA_STOPPED, CPA_RUNNING} cpa_run_t;

endpackage

// ---- core/cpa_pwm_action.sv ----
`timescale 1ns/1ps
// Compare PWM output action logic with APB register access.
module cpa_pwm_action
	import cpa_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic [5:0] pwm_out,
	output logic timer_underflow_event_out
);

	logic [15:0] compare_control_setting;
	logic [15:0] action_shadow;
	logic [15:0] output_action_setting;
	cpa_deadband_t deadband;
	logic [15:0] period;
	logic [15:0] cmp_val [CPA_PAIRS];
	logic [15:0] count;
	logic underflow;
	cpa_run_t run_state;
	logic [5:0] stuck_high;
	logic [5:0] phase_src;
	logic [5:0] phase_on;
	logic [7:0] hold_cnt [CPA_OUTS];
	logic [5:0] next_pwm;
	logic wr_take;
	logic rd_take;
	logic addr_ok;
	logic cmp_enable;
	logic immediate_mode;
	logic active_load;
	logic [15:0] load_value;
	logic [31:0] next_rdata;

	// An access is taken in the first access-phase cycle, answered next.
	assign wr_take = psel_in && penable_in && !pready_out && pwrite_in;
	assign rd_take = psel_in && penable_in && !pready_out && !pwrite_in;
	assign cmp_enable = compare_control_setting[CPA_CC_ENABLE_BIT];
	assign immediate_mode = compare_control_setting[CPA_CC_RELOAD_LSB +: 2]
		== CPA_RELOAD_IMMEDIATE;

	// Moment and value of each load into the active action setting while running; the
	// immediate mode loads the incoming write data, not the old shadow.
	assign active_load = immediate_mode
		? (wr_take && paddr_in == CPA_OFS_ACTION) : underflow;
	assign load_value = immediate_mode ? pwdata_in[15:0] : action_shadow;

	// Address decode; anything off the map is refused with an error.
	always_comb
	begin
		addr_ok = 1'b1;
		next_rdata = 32'h0000_0000;
		case (paddr_in)
			CPA_OFS_CMP_CTL: next_rdata[15:0] = compare_control_setting;
			CPA_OFS_ACTION: next_rdata[15:0] = action_shadow;
			CPA_OFS_DEADBAND:
			begin
				next_rdata[CPA_DB_ENABLE_BIT] = deadband.enable;
				next_rdata[CPA_DB_DELAY_LSB +: 8] = deadband.delay;
			end
			CPA_OFS_PERIOD: next_rdata[15:0] = period;
			CPA_OFS_CMP0: next_rdata[15:0] = cmp_val[0];
			CPA_OFS_CMP1: next_rdata[15:0] = cmp_val[1];
			CPA_OFS_CMP2: next_rdata[15:0] = cmp_val[2];
			CPA_OFS_STATUS:
			begin
				next_rdata[15:0] = count;
				next_rdata[21:16] = stuck_high;
				next_rdata[22] = run_state == CPA_RUNNING;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// APB answer: one wait cycle, pready and error for a single cycle.
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end
		else
		begin
			pready_out <= wr_take || rd_take;
			pslverr_out <= (wr_take || rd_take) && !addr_ok;
			if (rd_take)
				prdata_out <= next_rdata;
		end
	end

	// Configuration registers written by software.
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
		begin
			compare_control_setting <= CPA_RST_CMP_CTL;
			deadband <= '0;
			period <= CPA_RST_PERIOD;
			for (int i = 0; i < CPA_PAIRS; i++)
				cmp_val[i] <= CPA_RST_CMP;
		end
		else if (wr_take)
		begin
			case (paddr_in)
				CPA_OFS_CMP_CTL: compare_control_setting <= pwdata_in[15:0];
				CPA_OFS_DEADBAND:
				begin
					deadband.enable <= pwdata_in[CPA_DB_ENABLE_BIT];
					deadband.delay <= pwdata_in[CPA_DB_DELAY_LSB +: 8];
				end
				CPA_OFS_PERIOD: period <= pwdata_in[15:0];
				CPA_OFS_CMP0: cmp_val[0] <= pwdata_in[15:0];
				CPA_OFS_CMP1: cmp_val[1] <= pwdata_in[15:0];
				CPA_OFS_CMP2: cmp_val[2] <= pwdata_in[15:0];
				default: ;
			endcase
		end
	end

	// Shadow of the action setting, always holding the last write.
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
			action_shadow <= CPA_RST_ACTION;
		else if (wr_take && paddr_in == CPA_OFS_ACTION)
			action_shadow <= pwdata_in[15:0];
	end

	// Run state follows the compare enable; leaving it is a full restart.
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
			run_state <= CPA_STOPPED;
		else
		begin
			case (run_state)
				CPA_STOPPED:
					if (cmp_enable)
						run_state <= CPA_RUNNING;
				CPA_RUNNING:
					if (!cmp_enable)
						run_state <= CPA_STOPPED;
				default: run_state <= CPA_STOPPED;
			endcase
		end
	end

	// Down counter; underflow marks the reload point of each period.
	assign underflow = run_state == CPA_RUNNING && count == 16'h0000;
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
		begin
			count <= CPA_RST_PERIOD;
			timer_underflow_event_out <= 1'b0;
		end
		else if (run_state != CPA_RUNNING)
		begin
			count <= period;
			timer_underflow_event_out <= 1'b0;
		end
		else
		begin
			count <= underflow ? period : count - 16'h0001;
			timer_underflow_event_out <= underflow;
		end
	end

	// Active action setting: follows the shadow while stopped; when running, loaded at once or at underflow per mode.
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
			output_action_setting <= CPA_RST_ACTION;
		else if (run_state != CPA_RUNNING)
			output_action_setting <= action_shadow;
		else if (immediate_mode && wr_take && paddr_in == CPA_OFS_ACTION)
			output_action_setting <= pwdata_in[15:0];
		else if (!immediate_mode && underflow)
			output_action_setting <= action_shadow;
	end

	// With dead-band on, a move from a forced code to an active code sticks active-high.
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
			stuck_high <= 6'h00;
		else if (run_state != CPA_RUNNING)
			stuck_high <= 6'h00;
		else
		begin
			for (int i = 0; i < CPA_OUTS; i++)
			begin
				if (deadband.enable && active_load
					&& (output_action_setting[2*i +: 2] == CPA_ACT_FORCE_LOW
					|| output_action_setting[2*i +: 2] == CPA_ACT_FORCE_HIGH)
					&& (load_value[2*i +: 2] == CPA_ACT_ACTIVE_LOW
					|| load_value[2*i +: 2] == CPA_ACT_ACTIVE_HIGH))
					stuck_high[i] <= 1'b1;
			end
		end
	end

	// Raw compare phases: even output true phase, odd output complement.
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in || run_state != CPA_RUNNING)
			phase_src <= 6'h00;
		else
		begin
			for (int p = 0; p < CPA_PAIRS; p++)
			begin
				phase_src[2*p] <= count < cmp_val[p];
				phase_src[2*p+1] <= !(count < cmp_val[p]);
			end
		end
	end

	// Dead-band: each phase turns on only after its delay has elapsed.
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in || run_state != CPA_RUNNING)
		begin
			phase_on <= 6'h00;
			for (int i = 0; i < CPA_OUTS; i++)
				hold_cnt[i] <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < CPA_OUTS; i++)
			begin
				if (!phase_src[i])
				begin
					hold_cnt[i] <= 8'h00;
					phase_on[i] <= 1'b0;
				end
				else if (!deadband.enable)
					phase_on[i] <= 1'b1;
				else if (hold_cnt[i] >= deadband.delay)
					phase_on[i] <= 1'b1;
				else
					hold_cnt[i] <= hold_cnt[i] + 8'h01;
			end
		end
	end

	// Polarity and forcing per output from the active action codes; a stuck output acts as active-high.
	always_comb
	begin
		next_pwm = 6'h00;
		for (int i = 0; i < CPA_OUTS; i++)
		begin
			case (stuck_high[i] ? CPA_ACT_ACTIVE_HIGH
				: output_action_setting[2*i +: 2])
				CPA_ACT_FORCE_LOW: next_pwm[i] = 1'b0;
				CPA_ACT_ACTIVE_LOW: next_pwm[i] = !phase_on[i];
				CPA_ACT_ACTIVE_HIGH: next_pwm[i] = phase_on[i];
				CPA_ACT_FORCE_HIGH: next_pwm[i] = 1'b1;
				default: next_pwm[i] = 1'b0;
			endcase
		end
	end

	// Registered pins; low whenever compare or output enable is off.
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_b_in)
			pwm_out <= 6'h00;
		else if (run_state != CPA_RUNNING
			|| !compare_control_setting[CPA_CC_OUTEN_BIT])
			pwm_out <= 6'h00;
		else
			pwm_out <= next_pwm;
	end

endmodule

// ---- bench/cpa_monitor.sv ----
`timescale 1ns/1ps
// Port-level checks for the compare PWM action block.
module cpa_monitor
	import cpa_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [5:0] pwm_out,
	input wire logic timer_underflow_event_out
);
	logic tk;
	logic wa;
	logic [15:0] cc;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	// A request is taken in its first access cycle.
	assign tk = psel_in && penable_in && !pready_out;
	assign wa = tk && pwrite_in && paddr_in == CPA_OFS_ACTION;
	// Tracks the last compare control word written.
	always_ff @(posedge ref_clk_in)
		if (!rst_b_in)
			cc <= '0;
		else if (tk && pwrite_in && paddr_in == CPA_OFS_CMP_CTL)
			cc <= pwdata_in[15:0];
	property p_ans; tk |=> pready_out; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_pls; pready_out |=> !pready_out; endproperty
	a_pls: assert property (p_pls) else $error("long ready");
	property p_err; tk && paddr_in > 8'h1f |=> pslverr_out; endproperty
	a_err: assert property (p_err) else $error("no slave error");
	property p_uf; timer_underflow_event_out |=> !$stable(pwm_out) or
		!timer_underflow_event_out; endproperty
	a_uf: assert property (p_uf) else $error("long underflow");
	property p_rst;
		@(posedge ref_clk_in) disable iff (1'b0) !rst_b_in |=> pwm_out == 0;
	endproperty
	a_rst: assert property (p_rst) else $error("pins on in reset");
	property p_zero; wa && pwdata_in[11:0] == 0 &&
		cc[11:10] == CPA_RELOAD_IMMEDIATE |-> ##[1:3] pwm_out == 0; endproperty
	a_zero: assert property (p_zero) else $error("zero not low");
	property p_imm; wa && pwdata_in[11:0] == 12'hfff && cc[15] && cc[9] &&
		cc[11:10] == CPA_RELOAD_IMMEDIATE |-> ##[1:3] pwm_out == 6'h3f;
	endproperty
	a_imm: assert property (p_imm) else $error("late action");
	property p_off; tk && pwrite_in && paddr_in == CPA_OFS_CMP_CTL &&
		!pwdata_in[15] |-> ##[1:3] pwm_out == 0 ##1 pwm_out == 0; endproperty
	a_off: assert property (p_off) else $error("pins on when off");
	c_wr: cover property (wa);
	c_uf: cover property (timer_underflow_event_out);
	c_err: cover property (pslverr_out);
endmodule
bind cpa_pwm_action cpa_monitor u_mon (.ref_clk_in(ref_clk_in),
	.rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .pwm_out(pwm_out),
	.timer_underflow_event_out(timer_underflow_event_out));

// ---- bench/cpa_power_stage.sv ----
`timescale 1ns/1ps
// Power stage model: counts cycles in which one leg conducts on both sides.
module cpa_power_stage
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [5:0] pwm_in,
	output logic [15:0] shoot_count_out
);
	// Both switches of one leg on is a shoot-through.
	always_ff @(posedge ref_clk_in)
		if (!rst_b_in)
			shoot_count_out <= '0;
		else if ((pwm_in[0] && pwm_in[1]) || (pwm_in[2] && pwm_in[3]) ||
			(pwm_in[4] && pwm_in[5]))
			shoot_count_out <= shoot_count_out + 16'h0001;
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the compare PWM action block.
module tb;
	import cpa_pkg::*;
	logic ref_clk_in = 0;
	logic rst_b_in = 0;
	logic psel = 0;
	logic pen = 0;
	logic pwr = 0;
	logic [7:0] padr = '0;
	logic [31:0] pwd = '0;
	logic [31:0] prd, r;
	logic prdy, perr, uf, e;
	logic [5:0] pwm;
	logic [11:0] a;
	logic [15:0] shoot, s0;
	int fails = 0;
	int check_count = 0;
	int i;
	int g;
	// Clock of 8 ns period.
	always #4 ref_clk_in = ~ref_clk_in;
	cpa_pwm_action DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr),
		.pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
		.pslverr_out(perr), .pwm_out(pwm), .timer_underflow_event_out(uf));
	cpa_power_stage u_stage (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.pwm_in(pwm), .shoot_count_out(shoot));
	task automatic stop_test();
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	// One APB transfer; holds the request until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_in);
		psel <= 1;
		pwr <= w;
		padr <= ad;
		pwd <= d;
		@(posedge ref_clk_in);
		pen <= 1;
		do
		begin
			@(posedge ref_clk_in);
			n++;
		end
		while (prdy !== 1'b1 && n < 9);
		r = prd;
		e = perr;
		psel <= 0;
		pen <= 0;
		if (n >= 9)
		begin
			fails++;
			stop_test();
		end
	endtask
	// Waits for a timer underflow pulse, bounded.
	task automatic wuf();
		int n;
		for (n = 0; n < 200 && uf !== 1'b1; n++)
			@(posedge ref_clk_in);
		if (n >= 200)
		begin
			fails++;
			stop_test();
		end
	endtask
	// Waits until one pin shows a level, bounded; counts the edges waited.
	task automatic wpin(input int b, input logic v, output int n);
		for (n = 0; n < 200 && pwm[b] !== v; n++)
			@(posedge ref_clk_in);
		if (n >= 200)
		begin
			fails++;
			stop_test();
		end
	endtask
	// Pin levels for an action word with every compare at zero.
	function automatic logic [5:0] exp_pins(input logic [11:0] v);
		for (int k = 0; k < 6; k++)
			case (v[2*k+:2])
				CPA_ACT_FORCE_LOW: exp_pins[k] = 1'b0;
				CPA_ACT_FORCE_HIGH: exp_pins[k] = 1'b1;
				CPA_ACT_ACTIVE_HIGH: exp_pins[k] = k[0];
				default: exp_pins[k] = !k[0];
			endcase
	endfunction
	// Main sequence of scenarios.
	initial
	begin
		i = $urandom(32'h0baf);
		wt(8);
		rst_b_in <= 1;
		chk(32'(pwm), 0);
		apb(0, CPA_OFS_PERIOD, 0);
		chk(r, 32'(CPA_RST_PERIOD));
		apb(0, 8'h20, 0);
		chk({e, r[30:0]}, 32'h80000000);
		apb(1, CPA_OFS_CMP_CTL, 32'h8a00);
		for (i = 0; i < 14; i++)
		begin
			a = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
			apb(1, CPA_OFS_ACTION, {20'h0, a});
			wt(3);
			chk(32'(pwm), 32'(exp_pins(a)));
		end
		apb(1, CPA_OFS_CMP_CTL, 32'h0);
		apb(0, CPA_OFS_STATUS, 0);
		chk({r[22], 25'h0, pwm}, 0);
		apb(1, CPA_OFS_PERIOD, 32'h40);
		apb(1, CPA_OFS_ACTION, 32'h0);
		apb(1, CPA_OFS_CMP_CTL, 32'h8200);
		wuf();
		apb(1, CPA_OFS_ACTION, 32'hfff);
		wt(3);
		chk(32'(pwm), 0);
		wuf();
		wt(3);
		chk(32'(pwm), 32'h3f);
		apb(1, CPA_OFS_DEADBAND, 32'h31);
		apb(1, CPA_OFS_CMP_CTL, 32'h8a00);
		apb(1, CPA_OFS_ACTION, 32'h0);
		apb(1, CPA_OFS_ACTION, 32'h660);
		wt(3);
		apb(0, CPA_OFS_STATUS, 0);
		chk(32'(r[21:16]), 32'h3c);
		apb(1, CPA_OFS_CMP_CTL, 32'h0);
		for (i = 0; i < 3; i++)
			apb(1, CPA_OFS_CMP0 + 8'(4 * i), 32'h20);
		apb(1, CPA_OFS_ACTION, 32'haa0);
		apb(1, CPA_OFS_CMP_CTL, 32'h8a00);
		apb(0, CPA_OFS_STATUS, 0);
		chk(32'(r[21:16]), 0);
		s0 = shoot;
		wt(300);
		chk(32'(shoot - s0), 0);
		// The gap from one leg falling to its partner rising is the delay.
		wpin(2, 1'b1, g);
		wpin(2, 1'b0, g);
		wpin(3, 1'b1, g);
		chk(32'(g), 32'h3);
		stop_test();
	end
endmodule
